/* File: rtl/pcc_command_if.v */
/*
 * performance counters with a register command port, classic wishbone
 * slave with 32-bit data; 64-bit registers take two aligned words.
 * assumes one clock, synchronous reset, events as one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"

// Operation
// - each counter is an N-bit up-counter of configured events
// - after a write the counter continues from the written value
// - freeze stops all counters, holding their exact values
// - unfreeze resumes counting from the held values
// - counters sit at base offset plus index times stride
// - counter bits above N read zero; value resets to zero
// - without monitoring support no counter register exists
// - without command support the command register is reserved-zero
// - while busy, operand A and command code writes are dropped
// - accepted command clears response and sets in-progress in the same cycle
// - code 240 enables, 241 disables counter named in operand A
// - code 242 resets all configuration, 243 all values
// - code 244 freezes, 245 unfreezes all counters
// - codes 0 to 239 and 246 to 255 are reserved
// - response bit 0 is 1 while executing, 0 once done
// - status bits 7:1: 0 success, 1 undefined, 2 abort
// - unsupported commands complete with undefined-command status
// - write-only extended operand at 408h, dropped while busy
module pcc_command_if (
    input wire ref_clk,
    input wire srst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`PCC_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [`PCC_NUM_COUNTER_VALUE-1:0] eventIn,
    input wire globalCmdBusy,
    output wire frozen,
    output wire [`PCC_NUM_COUNTER_VALUE-1:0] cntrEnabled,
    output wire cmdBusy
);
    localparam NC = `PCC_NUM_COUNTER_VALUE;
    localparam [31:0] CTRL_RST = `PCC_CTRL_RESET;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg pmsSupport_reg;
    reg ecmdSupport_reg;
    reg frozen_reg;
    reg [NC-1:0] enable_reg;
    reg [47:0] operandA_reg;
    reg [63:0] operandB_reg;
    reg [7:0] cmdCode_reg;
    reg inProgress_reg;
    reg [6:0] status_reg;
    reg [31:0] rdData_next;
    reg [6:0] status_next;
    reg frozen_next;
    reg [NC-1:0] enable_next;
    reg clearAll;
    wire [`PCC_COUNTER_VALUE_W-1:0] cntrVal [0:NC-1];
    wire [NC-1:0] loadLo;
    wire [NC-1:0] loadHi;
    wire execute;
    wire finish;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // ack one cycle after the request, dropped the cycle after
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wrReq = req && wb_we_i && (wb_sel_i == 4'hF);
    wire rdReq = req && !wb_we_i;
    wire hitCmdLo = (wb_adr_i == `PCC_OFS_CMD_LO);
    wire hitCmdHi = (wb_adr_i == `PCC_OFS_CMD_HI);
    wire hitExtLo = (wb_adr_i == `PCC_OFS_EXT_LO);
    wire hitExtHi = (wb_adr_i == `PCC_OFS_EXT_HI);
    wire hitRspLo = (wb_adr_i == `PCC_OFS_RSP_LO);
    wire hitCtrl = (wb_adr_i == `PCC_OFS_CTRL);
    wire cmdWrOk = wrReq && ecmdSupport_reg && !inProgress_reg;
    wire cmdAccept = cmdWrOk && hitCmdLo;

    // counter window: base + index * stride, words 0 and 1 of each slot
    wire inCntrWin = (wb_adr_i < (`PCC_OFS_COUNTER_VALUE_BASE + NC * `PCC_COUNTER_VALUE_STRIDE));
    wire [`PCC_ADR_W-1:0] cntrRel = wb_adr_i - `PCC_OFS_COUNTER_VALUE_BASE;
    wire [`PCC_COUNTER_VALUE_IDX_W-1:0] cntrIdx = cntrRel[`PCC_COUNTER_VALUE_IDX_W+3:4];
    wire [3:0] cntrOfs = cntrRel[3:0];
    wire cntrHit = pmsSupport_reg && inCntrWin;

    // ------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi = gi + 1) begin : g_counter_value
            assign loadLo[gi] = wrReq && cntrHit &&
                (cntrIdx == gi) && (cntrOfs == 4'h0);
            assign loadHi[gi] = wrReq && cntrHit &&
                (cntrIdx == gi) && (cntrOfs == 4'h4);
            pcc_counter u_counter_value (
                .ref_clk(ref_clk),
                .srst(srst),
                .eventIn(eventIn[gi]),
                .countOn(pmsSupport_reg && enable_reg[gi] &&
                    !frozen_reg),
                .clearVal(clearAll),
                .loadLo(loadLo[gi]),
                .loadHi(loadHi[gi]),
                .loadData(wb_dat_i),
                .value_reg(cntrVal[gi])
            );
        end
    endgenerate

    pcc_exec u_exec (
        .ref_clk(ref_clk),
        .srst(srst),
        .start(cmdAccept),
        .execute(execute),
        .finish(finish)
    );

    // ------------------------------------------------------------------
    // command execution
    // ------------------------------------------------------------------
    // a global command in flight aborts the enhanced one with no effect
    always @* begin
        status_next = status_reg;
        frozen_next = frozen_reg;
        enable_next = enable_reg;
        clearAll = 1'b0;
        if (execute) begin
            status_next = `PCC_SC_OK;
            if (globalCmdBusy) begin
                status_next = `PCC_SC_ABORT;
            end else begin
                case (cmdCode_reg)
                    `PCC_CMD_ENABLE: begin
                        if (operandA_reg < NC) begin
                            // unsupported: report only, leave enables alone
                            if (pmsSupport_reg) begin
                                enable_next[operandA_reg[`PCC_COUNTER_VALUE_IDX_W-1:0]]
                                    = 1'b1;
                            end else begin
                                status_next = `PCC_SC_UNDEF;
                            end
                        end else begin
                            status_next = `PCC_SC_BAD_COUNTER_VALUE;
                        end
                    end
                    `PCC_CMD_DISABLE: begin
                        if (operandA_reg < NC) begin
                            enable_next[operandA_reg[`PCC_COUNTER_VALUE_IDX_W-1:0]]
                                = 1'b0;
                        end else begin
                            status_next = `PCC_SC_BAD_COUNTER_VALUE;
                        end
                    end
                    `PCC_CMD_RST_CFG: begin
                        enable_next = {NC{1'b0}};
                    end
                    `PCC_CMD_RST_VAL: begin
                        clearAll = 1'b1;
                    end
                    `PCC_CMD_FREEZE: begin
                        frozen_next = 1'b1;
                    end
                    `PCC_CMD_UNFREEZE: begin
                        frozen_next = 1'b0;
                    end
                    default: begin
                        status_next = `PCC_SC_UNDEF;
                    end
                endcase
            end
        end
        if (cmdAccept) begin
            status_next = `PCC_SC_OK;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            pmsSupport_reg <= CTRL_RST[`PCC_CTRL_PMS_BIT];
            ecmdSupport_reg <= CTRL_RST[`PCC_CTRL_ECS_BIT];
            frozen_reg <= 1'b0;
            enable_reg <= {NC{1'b0}};
            operandA_reg <= 48'h0000_0000_0000;
            operandB_reg <= 64'h0000_0000_0000_0000;
            cmdCode_reg <= 8'h00;
            inProgress_reg <= 1'b0;
            status_reg <= 7'h00;
        end else begin
            frozen_reg <= frozen_next;
            enable_reg <= enable_next;
            status_reg <= status_next;
            if (wrReq && hitCtrl) begin
                pmsSupport_reg <= wb_dat_i[`PCC_CTRL_PMS_BIT];
                ecmdSupport_reg <= wb_dat_i[`PCC_CTRL_ECS_BIT];
            end
            if (cmdWrOk && hitCmdHi) begin
                operandA_reg[47:16] <= wb_dat_i;
            end
            if (cmdAccept) begin
                operandA_reg[15:0] <= wb_dat_i[31:16];
                cmdCode_reg <= wb_dat_i[7:0];
                inProgress_reg <= 1'b1;
            end else if (finish) begin
                inProgress_reg <= 1'b0;
            end
            if (cmdWrOk && hitExtLo) begin
                operandB_reg[31:0] <= wb_dat_i;
            end
            if (cmdWrOk && hitExtHi) begin
                operandB_reg[63:32] <= wb_dat_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // command and operand registers are write-only and read zero
    always @* begin
        rdData_next = 32'h0000_0000;
        if (hitRspLo && ecmdSupport_reg) begin
            rdData_next = {24'h00_0000, status_reg, inProgress_reg};
        end else if (hitCtrl) begin
            rdData_next = {{(24-NC){1'b0}}, enable_reg, 5'h00, frozen_reg,
                ecmdSupport_reg, pmsSupport_reg};
        end else if (cntrHit && cntrOfs == 4'h0) begin
            rdData_next = cntrVal[cntrIdx][31:0];
        end else if (cntrHit && cntrOfs == 4'h4) begin
            rdData_next = {16'h0000,
                cntrVal[cntrIdx][`PCC_COUNTER_VALUE_W-1:32]};
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rdReq) begin
                wb_dat_o <= rdData_next;
            end
        end
    end

    assign frozen = frozen_reg;
    assign cntrEnabled = enable_reg;
    assign cmdBusy = inProgress_reg;
endmodule

`default_nettype wire

/* File: rtl/pcc_counter.v */
/*
 * one performance event counter with load, clear and gated increment.
 * assumes eventIn is a one-cycle pulse per event, synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"

module pcc_counter (
    input wire ref_clk,
    input wire srst,
    input wire eventIn,
    input wire countOn,
    input wire clearVal,
    input wire loadLo,
    input wire loadHi,
    input wire [31:0] loadData,
    output reg [`PCC_COUNTER_VALUE_W-1:0] value_reg
);
    reg [`PCC_COUNTER_VALUE_W-1:0] value_next;

    // ------------------------------------------------------------------
    // counting
    // ------------------------------------------------------------------
    // a software write wins over an event in the same cycle
    always @* begin
        value_next = value_reg;
        if (clearVal) begin
            value_next = {`PCC_COUNTER_VALUE_W{1'b0}};
        end else if (loadLo) begin
            value_next = {value_reg[`PCC_COUNTER_VALUE_W-1:32], loadData};
        end else if (loadHi) begin
            value_next = {loadData[`PCC_COUNTER_VALUE_W-33:0], value_reg[31:0]};
        end else if (countOn && eventIn) begin
            value_next = value_reg + 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            value_reg <= {`PCC_COUNTER_VALUE_W{1'b0}};
        end else begin
            value_reg <= value_next;
        end
    end
endmodule

`default_nettype wire

/* File: rtl/pcc_defines.vh */
/*
 * constants for the performance counter command block: register byte
 * offsets, field positions, command codes, status codes.
 * assumes a 32-bit classic wishbone slave; 64-bit registers are two words.
 */
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// ------------------------------------------------------------------
// sizes
// ------------------------------------------------------------------
`define PCC_NUM_COUNTER_VALUE 4
`define PCC_COUNTER_VALUE_IDX_W 2
`define PCC_COUNTER_VALUE_W 48
`define PCC_ADR_W 12

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define PCC_OFS_CMD_LO 12'h400
`define PCC_OFS_CMD_HI 12'h404
`define PCC_OFS_EXT_LO 12'h408
`define PCC_OFS_EXT_HI 12'h40C
`define PCC_OFS_RSP_LO 12'h410
`define PCC_OFS_RSP_HI 12'h414
`define PCC_OFS_CTRL 12'h420
`define PCC_OFS_COUNTER_VALUE_BASE 12'h000
`define PCC_COUNTER_VALUE_STRIDE 12'h010

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define PCC_CTRL_PMS_BIT 0
`define PCC_CTRL_ECS_BIT 1
`define PCC_CTRL_FRZ_BIT 2
`define PCC_CTRL_EN_LSB 8
`define PCC_CTRL_RESET 32'h0000_0003

// ------------------------------------------------------------------
// command and status codes
// ------------------------------------------------------------------
`define PCC_CMD_ENABLE 8'hF0
`define PCC_CMD_DISABLE 8'hF1
`define PCC_CMD_RST_CFG 8'hF2
`define PCC_CMD_RST_VAL 8'hF3
`define PCC_CMD_FREEZE 8'hF4
`define PCC_CMD_UNFREEZE 8'hF5
`define PCC_SC_OK 7'h00
`define PCC_SC_UNDEF 7'h01
`define PCC_SC_ABORT 7'h02
`define PCC_SC_BAD_COUNTER_VALUE 7'h10

`endif

/* File: rtl/pcc_exec.v */
/*
 * command execution sequencer: one-hot idle, run, done.
 * assumes start is a one-cycle pulse and busy is shown by the parent.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"

module pcc_exec (
    input wire ref_clk,
    input wire srst,
    input wire start,
    output wire execute,
    output wire finish
);
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    reg [2:0] state_reg;
    reg [2:0] state_next;

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    // one cycle of visible in-progress before the effect lands
    always @* begin
        case (state_reg)
            ST_IDLE: begin
                state_next = start ? ST_RUN : ST_IDLE;
            end
            ST_RUN: begin
                state_next = ST_DONE;
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign execute = (state_reg == ST_RUN);
    assign finish = (state_reg == ST_DONE);
endmodule

`default_nettype wire

/* File: sim/pcc_cmd_monitor.sv */
/*
 * concurrent checks on the ports of the performance counter command block.
 * assumes a master that drops cyc and stb for a cycle after every ack.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"

module pcc_cmd_monitor (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PCC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic globalCmdBusy,
    input wire logic frozen,
    input wire logic [`PCC_NUM_COUNTER_VALUE-1:0] cntrEnabled,
    input wire logic cmdBusy
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    logic [31:0] ctrlSh;
    // shadow of the support bits, so a cleared bit silences the checks
    always @(posedge ref_clk) begin
        if (srst) begin
            ctrlSh <= `PCC_CTRL_RESET;
        end else if (take && wb_we_i && wb_adr_i == `PCC_OFS_CTRL
            && wb_sel_i == 4'hF) begin
            ctrlSh <= wb_dat_i;
        end
    end
    wire cmdWr = take && wb_we_i && wb_adr_i == `PCC_OFS_CMD_LO
        && wb_sel_i == 4'hF && !cmdBusy && ctrlSh[`PCC_CTRL_ECS_BIT];
    wire cmdOk = cmdWr && !globalCmdBusy;
    wire [7:0] code = wb_dat_i[7:0];
    sequence busyRun;
        cmdBusy [*2] ##1 !cmdBusy;
    endsequence
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_ack_next: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_busy_run: assert property (cmdWr |=> busyRun)
        else $error("busy flag sequence wrong");
    a_busy_cause: assert property ($rose(cmdBusy) |-> $past(cmdWr))
        else $error("busy without command");
    a_freeze_cmd: assert property (cmdOk && code == `PCC_CMD_FREEZE |-> ##2 frozen)
        else $error("freeze not applied");
    a_unfreeze_cmd: assert property (cmdOk && code == `PCC_CMD_UNFREEZE |-> ##2 !frozen)
        else $error("unfreeze not applied");
    a_frozen_cause: assert property ($changed(frozen) |-> $past(cmdWr, 2))
        else $error("frozen changed without command");
    a_enable_cmd: assert property (cmdOk && code == `PCC_CMD_ENABLE
        && wb_dat_i[31:18] == 14'h0000 && ctrlSh[`PCC_CTRL_PMS_BIT]
        |-> ##2 cntrEnabled[$past(wb_dat_i[17:16], 2)])
        else $error("enable not applied");
    a_abort_hold: assert property (cmdWr && globalCmdBusy |-> ##2
        (frozen == $past(frozen, 2) && cntrEnabled == $past(cntrEnabled, 2)))
        else $error("aborted command had an effect");
endmodule

bind pcc_command_if pcc_cmd_monitor u_pcc_cmd_monitor (.ref_clk(ref_clk),
    .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .globalCmdBusy(globalCmdBusy), .frozen(frozen),
    .cntrEnabled(cntrEnabled), .cmdBusy(cmdBusy));
`default_nettype wire

/* File: sim/test_perf_counter_command_interface.sv */
/*
 * self-checking bench with a behavioural counter model.
 * assumes the design answers every request; support bits are toggled once.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"

module test_perf_counter_command_interface;
    logic ref_clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, globalCmdBusy = 1'b0, wb_ack_o, frozen, cmdBusy;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0, eventIn = 4'h0, cntrEnabled, men;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, seed = 32'h0000_52FF;
    logic [47:0] mv [0:3];
    logic [7:0] codes [0:4];
    logic mfz, mpms;
    integer fail_count = 0, checked = 0, cycles = 0, i;

    pcc_command_if u_pcc_command_if (.ref_clk(ref_clk), .srst(srst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eventIn(eventIn),
        .globalCmdBusy(globalCmdBusy), .frozen(frozen),
        .cntrEnabled(cntrEnabled), .cmdBusy(cmdBusy));

    always #2 ref_clk = ~ref_clk;
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task chk(input logic [47:0] s, input logic [47:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wbx(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, 4'hF};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %0t no ack", $time);
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task rd_all();
        for (i = 0; i < 4; i++) begin
            wbx(1'b0, 12'h000 + i * 16, 32'h0);
            chk({16'h0, q}, {16'h0, mv[i][31:0]});
            wbx(1'b0, 12'h004 + i * 16, 32'h0);
            chk({16'h0, q}, {32'h0, mv[i][47:32]});
        end
    endtask
    // events sit high for one cycle each; the model counts what it drove
    task ev(input integer n);
        logic [31:0] r;
        repeat (n) begin
            @(posedge ref_clk);
            r = rnd();
            eventIn <= r[3:0];
            for (i = 0; i < 4; i++)
                if (mpms && !mfz && men[i] && r[i])
                    mv[i] = mv[i] + 48'h1;
        end
        @(posedge ref_clk);
        eventIn <= 4'h0;
        @(posedge ref_clk);
    endtask
    task cmd(input logic [7:0] c, input logic [47:0] opa);
        logic [6:0] st;
        logic b;
        integer n;
        wbx(1'b1, `PCC_OFS_EXT_LO, opa[31:0]);
        wbx(1'b1, `PCC_OFS_CMD_HI, opa[47:16]);
        wbx(1'b1, `PCC_OFS_CMD_LO, {opa[15:0], 8'h00, c});
        b = 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            if (cmdBusy === 1'b1) b = 1'b1;
            n++;
        end while (cmdBusy !== 1'b0 && n < 20);
        chk(b, 1'b1);
        if (c < `PCC_CMD_ENABLE || c > `PCC_CMD_UNFREEZE) st = `PCC_SC_UNDEF;
        else if (globalCmdBusy) st = `PCC_SC_ABORT;
        else if (c <= `PCC_CMD_DISABLE && opa > 3) st = `PCC_SC_BAD_COUNTER_VALUE;
        else if (c == `PCC_CMD_ENABLE && !mpms) st = `PCC_SC_UNDEF;
        else begin
            st = `PCC_SC_OK;
            case (c)
                `PCC_CMD_ENABLE: men[opa[1:0]] = 1'b1;
                `PCC_CMD_DISABLE: men[opa[1:0]] = 1'b0;
                `PCC_CMD_RST_CFG: men = 4'h0;
                `PCC_CMD_RST_VAL: for (i = 0; i < 4; i++) mv[i] = 48'h0;
                `PCC_CMD_FREEZE: mfz = 1'b1;
                default: mfz = 1'b0;
            endcase
        end
        wbx(1'b0, `PCC_OFS_RSP_LO, 32'h0);
        chk({16'h0, q}, {40'h0, st, 1'b0});
        chk({44'h0, cntrEnabled}, {44'h0, men});
        chk({47'h0, frozen}, {47'h0, mfz});
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        for (i = 0; i < 4; i++) mv[i] = 48'h0;
        {men, mfz} = 5'h00;
        mpms = 1'b1;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        rd_all();
        wbx(1'b0, `PCC_OFS_CTRL, 32'h0);
        chk({16'h0, q}, {16'h0, `PCC_CTRL_RESET});
        wbx(1'b0, 12'h800, 32'h0);
        chk({16'h0, q}, 48'h0);
        $display("test done: reset values");
        for (i = 0; i < 5; i++) cmd(`PCC_CMD_ENABLE, i);
        ev(40);
        rd_all();
        cmd(`PCC_CMD_DISABLE, 48'h2);
        ev(30);
        rd_all();
        $display("test done: enable and disable");
        mv[0][31:0] = rnd();
        wbx(1'b1, 12'h000, mv[0][31:0]);
        wbx(1'b1, 12'h014, 32'hFFFF_FFFF);
        wbx(1'b1, 12'h010, 32'hFFFF_FFFC);
        mv[1] = 48'hFFFF_FFFF_FFFC;
        ev(20);
        rd_all();
        $display("test done: written values and wrap");
        cmd(`PCC_CMD_FREEZE, 48'h0);
        ev(20);
        rd_all();
        cmd(`PCC_CMD_UNFREEZE, 48'h0);
        ev(20);
        rd_all();
        $display("test done: freeze and unfreeze");
        wbx(1'b1, `PCC_OFS_CTRL, 32'h0000_0002);
        mpms = 1'b0;
        ev(10);
        wbx(1'b0, 12'h010, 32'h0);
        chk({16'h0, q}, 48'h0);
        cmd(`PCC_CMD_ENABLE, 48'h0);
        wbx(1'b1, `PCC_OFS_CTRL, 32'h0000_0000);
        wbx(1'b1, `PCC_OFS_CMD_LO, {24'h00_0000, `PCC_CMD_FREEZE});
        wbx(1'b0, `PCC_OFS_RSP_LO, 32'h0);
        chk({16'h0, q}, 48'h0);
        chk({46'h0, cmdBusy, frozen}, {46'h0, 1'b0, mfz});
        wbx(1'b1, `PCC_OFS_CTRL, `PCC_CTRL_RESET);
        mpms = 1'b1;
        rd_all();
        $display("test done: support bits off");
        codes = '{8'h00, 8'hEF, 8'hF6, 8'hFF, 8'h00};
        codes[4] = rnd() % 240;
        for (integer k = 0; k < 5; k++) cmd(codes[k], {16'h0, rnd()});
        globalCmdBusy <= 1'b1;
        cmd(`PCC_CMD_FREEZE, 48'h0);
        globalCmdBusy <= 1'b0;
        $display("test done: reserved codes and abort");
        cmd(`PCC_CMD_RST_VAL, 48'h0);
        cmd(`PCC_CMD_RST_CFG, 48'h0);
        ev(10);
        rd_all();
        $display("test done: global resets");
        give_verdict();
    end
endmodule
`default_nettype wire
